// ==== atcr_cfg.svh ====
// Offsets, field positions, reset values and limits of the transfer control block.
`ifndef ATCR_CFG_SVH
`define ATCR_CFG_SVH

`define ATCR_OFF_XFER_CTRL 16'hff8b
`define ATCR_OFF_DRIVE_SEL 16'hff8c
`define ATCR_OFF_INT_REASON 16'hff8d
`define ATCR_OFF_ERR_REPORT 16'hff8e

`define ATCR_XC_RESET 8'h08
`define ATCR_XC_WMASK 8'h7f
`define ATCR_XC_RSVD_BIT 7
`define ATCR_XC_MODE_BIT 6
`define ATCR_XC_DMA_BIT 5
`define ATCR_XC_ULTRA_BIT 4
`define ATCR_XC_OWN_BIT 3
`define ATCR_XC_ROUTE_MSB 2
`define ATCR_XC_ROUTE_LSB 0

`define ATCR_DS_RESET 8'he0
`define ATCR_DS_WMASK 8'h10
`define ATCR_DS_ONES 8'he0
`define ATCR_DS_DRV_BIT 4

`define ATCR_IR_RESET 8'h00
`define ATCR_IR_WMASK 8'h07
`define ATCR_IR_RELEASE_BIT 2
`define ATCR_IR_IO_BIT 1
`define ATCR_IR_COD_BIT 0

`define ATCR_ER_RESET 8'h00
`define ATCR_ER_WMASK 8'hfe
`define ATCR_ER_SENSE_MSB 7
`define ATCR_ER_SENSE_LSB 4
`define ATCR_ER_MCR_BIT 3
`define ATCR_ER_ABRT_BIT 2
`define ATCR_ER_EOM_BIT 1

`define ATCR_RT_TO_HOST 3'h0
`define ATCR_RT_HOST_TO_MEM 3'h1
`define ATCR_RT_MCU_TO_MEM 3'h2
`define ATCR_RT_MEM_TO_MCU 3'h3
`define ATCR_RT_HOST_TO_MCU 3'h4
`define ATCR_RT_MCU_TO_HOST 3'h5

`define ATCR_PIO_MAX 32'h0000ffff
`define ATCR_DMA_MAX 32'hffffffff
`define ATCR_SPB_BYTES 32'h0000000c
`define ATCR_RDATA_UNMAPPED 8'h00

`endif

// ==== atcr_pkg.sv ====
// State types of the transfer control block.
`default_nettype none
package atcr_pkg;
  typedef struct packed {
    logic [7:0] value_reg;
  } atcr_field_t;

  typedef struct packed {
    logic start_reg;
    logic [2:0] route_reg;
    logic dma_reg;
    logic multi_reg;
    logic ultra_reg;
    logic fixed_reg;
    logic use_cnt_reg;
    logic [31:0] max_reg;
  } atcr_route_st_t;

  typedef struct packed {
    logic [7:0] rdata_reg;
    logic cmd_acc_reg;
    logic int_o_reg;
    logic int_oe_reg;
  } atcr_state_t;
endpackage
`default_nettype wire

// ==== atcr_field.sv ====
// One 8-bit control register with write mask and read-as-one bits.
`default_nettype none
module atcr_field #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hff,
  parameter logic [7:0] ONES = 8'h00
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  input wire logic ext_wr,
  input wire logic [7:0] ext_wdata,
  output logic [7:0] value
);
  atcr_pkg::atcr_field_t s_reg;
  atcr_pkg::atcr_field_t s_next;

  if ((WMASK & ONES) != 8'h00) begin : g_bad_mask
    $error("atcr_field: a writable bit cannot also read as one");
  end

  // The processor write is applied last so it wins a same-cycle collision.
  always_comb begin
    s_next = s_reg;
    if (ext_wr) begin
      s_next.value_reg = (s_reg.value_reg & ~WMASK) | (ext_wdata & WMASK);
    end
    if (cpu_wr) begin
      s_next.value_reg = (s_next.value_reg & ~WMASK) | (cpu_wdata & WMASK);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{value_reg: RST_VAL};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign value = s_reg.value_reg | ONES;
endmodule
`default_nettype wire

// ==== atcr_route.sv ====
// Transfer route decoder that launches a transfer with its byte limit.
`include "atcr_cfg.svh"
`default_nettype none
module atcr_route (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] ctrl,
  input wire logic trigger,
  output logic start,
  output logic [2:0] route,
  output logic dma,
  output logic multi,
  output logic ultra,
  output logic fixed12,
  output logic use_cnt,
  output logic [31:0] max_bytes
);
  atcr_pkg::atcr_route_st_t s_reg;
  atcr_pkg::atcr_route_st_t s_next;
  logic [2:0] code;
  logic req_dma;

  assign code = ctrl[`ATCR_XC_ROUTE_MSB:`ATCR_XC_ROUTE_LSB];
  assign req_dma = ctrl[`ATCR_XC_DMA_BIT];

  always_comb begin
    s_next = s_reg;
    s_next.start_reg = 1'b0;
    if (trigger) begin
      s_next.route_reg = code;
      s_next.multi_reg = ctrl[`ATCR_XC_MODE_BIT];
      // Ultra only takes effect with DMA and multi-word both set.
      s_next.ultra_reg = ctrl[`ATCR_XC_ULTRA_BIT] & req_dma &
                         ctrl[`ATCR_XC_MODE_BIT];
      s_next.dma_reg = req_dma;
      s_next.fixed_reg = 1'b0;
      s_next.use_cnt_reg = 1'b1;
      s_next.start_reg = 1'b1;
      case (code)
        `ATCR_RT_TO_HOST, `ATCR_RT_HOST_TO_MEM: begin
          s_next.max_reg = req_dma ? `ATCR_DMA_MAX : `ATCR_PIO_MAX;
        end
        `ATCR_RT_MCU_TO_MEM, `ATCR_RT_MEM_TO_MCU: begin
          s_next.max_reg = `ATCR_DMA_MAX;
        end
        `ATCR_RT_HOST_TO_MCU: begin
          s_next.dma_reg = 1'b0;
          s_next.ultra_reg = 1'b0;
          s_next.fixed_reg = 1'b1;
          s_next.use_cnt_reg = 1'b0;
          s_next.max_reg = `ATCR_SPB_BYTES;
        end
        `ATCR_RT_MCU_TO_HOST: begin
          s_next.fixed_reg = 1'b1;
          s_next.use_cnt_reg = 1'b0;
          s_next.max_reg = `ATCR_SPB_BYTES;
        end
        default: begin
          s_next = s_reg;
          s_next.start_reg = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign start = s_reg.start_reg;
  assign route = s_reg.route_reg;
  assign dma = s_reg.dma_reg;
  assign multi = s_reg.multi_reg;
  assign ultra = s_reg.ultra_reg;
  assign fixed12 = s_reg.fixed_reg;
  assign use_cnt = s_reg.use_cnt_reg;
  assign max_bytes = s_reg.max_reg;

  reserved_route_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && trigger && code[2] && code[1] |=> !start)
    else $error("reserved route started a transfer");

  fixed_len_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && trigger && code[2] && !code[1] |=>
    start && fixed12 && !use_cnt && max_bytes == `ATCR_SPB_BYTES)
    else $error("packet route not fixed at twelve bytes");

  pio_limit_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && trigger && !req_dma && code[2:1] == 2'b00 |=>
    max_bytes == `ATCR_PIO_MAX)
    else $error("programmed transfer limit wrong");

  host_pio_a: assert property (
    @(posedge clk) disable iff (rst)
    start && route == `ATCR_RT_HOST_TO_MCU |-> !dma && !ultra)
    else $error("host to processor route ran as DMA");

  ultra_gate_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && trigger && !code[2] |=> ultra == $past(
    ctrl[`ATCR_XC_ULTRA_BIT] & ctrl[`ATCR_XC_DMA_BIT] &
    ctrl[`ATCR_XC_MODE_BIT]))
    else $error("ultra DMA enabled without DMA and multi-word");
endmodule
`default_nettype wire

// ==== atcr_regs.sv ====
// Transfer control, drive select, interrupt reason and error registers.
// Operation
// - Reset clears transfer control to zero except the own-device bit, set.
// - Transfer control bit 6 picks multi-word DMA at 1, single-word at 0.
// - Transfer control bit 5 picks a DMA transfer at 1, PIO at 0.
// - Bit 4 picks ultra DMA, which needs bits 5 and 6 set as well.
// - Bit 3 makes the drive device 1 at 1 and device 0 at 0.
// - Bits 2 to 0 choose the route between host, memory and processor.
// - Routes 000 and 001 cap PIO at 65535 bytes and auto DMA near 4.3 GB.
// - Routes 100 and 101 move 12 bytes and both skip the count; 100 is PIO only.
// - The drive is selected while drive select bit 4 equals the own bit.
// - The host interrupt pin is enabled only while the drive is selected.
// - Interrupt reason holds bus release, direction and command flags.
// - Error report holds a sense field in 7..4 and three flags in 3..1.
// - Route 101 must be chosen to send the small packet buffer to the host.
// - The interrupt pin drives only with interrupts enabled and selected.
`include "atcr_cfg.svh"
`default_nettype none
module atcr_regs (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [7:0] RDATA,
  input wire logic HOST_SEL_WR,
  input wire logic [7:0] HOST_SEL_DATA,
  input wire logic HOST_INT_DISABLE,
  input wire logic HOST_INT_REQ,
  input wire logic HOST_CMD_WR,
  output logic CMD_ACCEPT,
  output logic SELECTED,
  output logic OWN_DEVICE,
  output logic HOST_INT_O,
  output logic HOST_INT_OE,
  output logic [2:0] INT_REASON,
  output logic [7:0] ERROR_REPORT,
  input wire logic XFER_TRIGGER,
  output logic XFER_START,
  output logic [2:0] XFER_ROUTE,
  output logic XFER_DMA,
  output logic XFER_MULTIWORD,
  output logic XFER_ULTRA,
  output logic XFER_FIXED12,
  output logic XFER_USE_COUNTER,
  output logic [31:0] XFER_MAX
);
  atcr_pkg::atcr_state_t s_reg;
  atcr_pkg::atcr_state_t s_next;
  logic [7:0] xfer_ctrl;
  logic [7:0] drive_sel;
  logic [7:0] int_reason;
  logic [7:0] err_report;
  logic wr_ctrl;
  logic wr_sel;
  logic wr_reason;
  logic wr_err;
  logic selected;

  // Strobes are honoured only in enabled cycles, so a frozen block misses them
  // silently: the source must hold a strobe until CE is high.
  assign wr_ctrl = WR_EN && ADDR == `ATCR_OFF_XFER_CTRL;
  assign wr_sel = WR_EN && ADDR == `ATCR_OFF_DRIVE_SEL;
  assign wr_reason = WR_EN && ADDR == `ATCR_OFF_INT_REASON;
  assign wr_err = WR_EN && ADDR == `ATCR_OFF_ERR_REPORT;

  atcr_field #(
    .RST_VAL(`ATCR_XC_RESET),
    .WMASK(`ATCR_XC_WMASK),
    .ONES(8'h00)
  ) u_xfer_ctrl (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .cpu_wr(wr_ctrl),
    .cpu_wdata(WDATA),
    .ext_wr(1'b0),
    .ext_wdata(8'h00),
    .value(xfer_ctrl)
  );

  atcr_field #(
    .RST_VAL(`ATCR_DS_RESET),
    .WMASK(`ATCR_DS_WMASK),
    .ONES(`ATCR_DS_ONES)
  ) u_drive_sel (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .cpu_wr(wr_sel),
    .cpu_wdata(WDATA),
    .ext_wr(HOST_SEL_WR),
    .ext_wdata(HOST_SEL_DATA),
    .value(drive_sel)
  );

  atcr_field #(
    .RST_VAL(`ATCR_IR_RESET),
    .WMASK(`ATCR_IR_WMASK),
    .ONES(8'h00)
  ) u_int_reason (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .cpu_wr(wr_reason),
    .cpu_wdata(WDATA),
    .ext_wr(1'b0),
    .ext_wdata(8'h00),
    .value(int_reason)
  );

  atcr_field #(
    .RST_VAL(`ATCR_ER_RESET),
    .WMASK(`ATCR_ER_WMASK),
    .ONES(8'h00)
  ) u_err_report (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .cpu_wr(wr_err),
    .cpu_wdata(WDATA),
    .ext_wr(1'b0),
    .ext_wdata(8'h00),
    .value(err_report)
  );

  atcr_route u_route (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .ctrl(xfer_ctrl),
    .trigger(XFER_TRIGGER),
    .start(XFER_START),
    .route(XFER_ROUTE),
    .dma(XFER_DMA),
    .multi(XFER_MULTIWORD),
    .ultra(XFER_ULTRA),
    .fixed12(XFER_FIXED12),
    .use_cnt(XFER_USE_COUNTER),
    .max_bytes(XFER_MAX)
  );

  // The own bit is never assumed by firmware, but a reset value of one keeps
  // the drive off a master-only bus until firmware configures it.
  assign selected = drive_sel[`ATCR_DS_DRV_BIT] ==
                    xfer_ctrl[`ATCR_XC_OWN_BIT];

  always_comb begin
    s_next = s_reg;
    s_next.rdata_reg = `ATCR_RDATA_UNMAPPED;
    if (RD_EN) begin
      case (ADDR)
        `ATCR_OFF_XFER_CTRL: s_next.rdata_reg = xfer_ctrl;
        `ATCR_OFF_DRIVE_SEL: s_next.rdata_reg = drive_sel;
        `ATCR_OFF_INT_REASON: s_next.rdata_reg = int_reason;
        `ATCR_OFF_ERR_REPORT: s_next.rdata_reg = err_report;
        default: s_next.rdata_reg = `ATCR_RDATA_UNMAPPED;
      endcase
    end else begin
      s_next.rdata_reg = s_reg.rdata_reg;
    end
    s_next.cmd_acc_reg = HOST_CMD_WR && selected;
    s_next.int_oe_reg = !HOST_INT_DISABLE && selected;
    s_next.int_o_reg = HOST_INT_REQ && !HOST_INT_DISABLE && selected;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_reg <= '0;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  assign RDATA = s_reg.rdata_reg;
  assign CMD_ACCEPT = s_reg.cmd_acc_reg;
  assign HOST_INT_OE = s_reg.int_oe_reg;
  assign HOST_INT_O = s_reg.int_o_reg;
  assign SELECTED = selected;
  assign OWN_DEVICE = xfer_ctrl[`ATCR_XC_OWN_BIT];
  assign INT_REASON = int_reason[`ATCR_IR_RELEASE_BIT:`ATCR_IR_COD_BIT];
  assign ERROR_REPORT = err_report;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  reset_value_a: assert property (
    @(posedge CLK) disable iff (1'b0)
    RST |-> xfer_ctrl == `ATCR_XC_RESET && OWN_DEVICE)
    else $error("transfer control wrong during reset");

  ctrl_write_a: assert property (
    CE && wr_ctrl |=> xfer_ctrl == ($past(WDATA) & `ATCR_XC_WMASK))
    else $error("transfer control write not stored as masked");

  mode_bits_a: assert property (
    CE && wr_ctrl |=> xfer_ctrl[`ATCR_XC_MODE_BIT] ==
    $past(WDATA[`ATCR_XC_MODE_BIT]) && xfer_ctrl[`ATCR_XC_DMA_BIT] ==
    $past(WDATA[`ATCR_XC_DMA_BIT]))
    else $error("DMA mode bits not stored");

  rsvd_zero_a: assert property (
    xfer_ctrl[`ATCR_XC_RSVD_BIT] == 1'b0)
    else $error("reserved control bit reads one");

  own_bit_a: assert property (
    CE && wr_ctrl && !wr_sel |=> OWN_DEVICE ==
    $past(WDATA[`ATCR_XC_OWN_BIT]))
    else $error("own-device bit not written");

  select_match_a: assert property (
    SELECTED == (drive_sel[`ATCR_DS_DRV_BIT] == OWN_DEVICE))
    else $error("selection does not follow drive bit match");

  host_sel_a: assert property (
    CE && HOST_SEL_WR && !wr_sel |=> drive_sel[`ATCR_DS_DRV_BIT] ==
    $past(HOST_SEL_DATA[`ATCR_DS_DRV_BIT]) &&
    drive_sel[7:5] == 3'h7)
    else $error("host drive select write lost");

  cpu_sel_a: assert property (
    CE && wr_sel |=> drive_sel[`ATCR_DS_DRV_BIT] ==
    $past(WDATA[`ATCR_DS_DRV_BIT]))
    else $error("processor drive select write lost");

  sel_fixed_a: assert property (
    drive_sel[7:5] == 3'h7 && drive_sel[3:0] == 4'h0)
    else $error("drive select fixed bits wrong");

  cmd_gate_a: assert property (
    CE && HOST_CMD_WR |=> CMD_ACCEPT == $past(SELECTED))
    else $error("command accepted while not selected");

  cmd_refused_a: assert property (
    CE && HOST_CMD_WR && !SELECTED |=> !CMD_ACCEPT)
    else $error("command accepted by an unselected drive");

  cmd_pulse_a: assert property (
    CE && !HOST_CMD_WR |=> !CMD_ACCEPT)
    else $error("command accept without a command write");

  int_enable_a: assert property (
    CE |=> HOST_INT_OE == $past(!HOST_INT_DISABLE && SELECTED))
    else $error("interrupt pin enable wrong");

  int_level_a: assert property (
    CE |=> HOST_INT_O ==
    $past(HOST_INT_REQ && !HOST_INT_DISABLE && SELECTED))
    else $error("interrupt pin level wrong");

  int_float_a: assert property (
    !HOST_INT_OE |-> !HOST_INT_O)
    else $error("interrupt level raised while pin released");

  reason_write_a: assert property (
    CE && wr_reason |=> INT_REASON == $past(WDATA[2:0]) &&
    int_reason[7:3] == 5'h00)
    else $error("interrupt reason write wrong");

  reason_upper_a: assert property (
    int_reason[7:3] == 5'h00)
    else $error("unused interrupt reason bits read one");

  err_write_a: assert property (
    CE && wr_err |=> ERROR_REPORT == ($past(WDATA) & `ATCR_ER_WMASK))
    else $error("error report write wrong");

  err_bit0_a: assert property (
    err_report[0] == 1'b0)
    else $error("unused error report bit reads one");

  unmapped_read_a: assert property (
    CE && RD_EN && ADDR[15:4] != 12'hff8 |=>
    RDATA == `ATCR_RDATA_UNMAPPED)
    else $error("unmapped read returned data");

  read_ctrl_a: assert property (
    CE && RD_EN && ADDR == `ATCR_OFF_XFER_CTRL |=> RDATA == $past(xfer_ctrl))
    else $error("transfer control read wrong");

  read_sel_a: assert property (
    CE && RD_EN && ADDR == `ATCR_OFF_DRIVE_SEL |=> RDATA == $past(drive_sel))
    else $error("drive select read wrong");

  read_reason_a: assert property (
    CE && RD_EN && ADDR == `ATCR_OFF_INT_REASON |=> RDATA == $past(int_reason))
    else $error("interrupt reason read wrong");

  read_err_a: assert property (
    CE && RD_EN && ADDR == `ATCR_OFF_ERR_REPORT |=> RDATA == $past(err_report))
    else $error("error report read wrong");

  read_hold_a: assert property (
    !CE || !RD_EN |=> $stable(RDATA))
    else $error("read data changed without an accepted read");

  // A frozen block must keep its four registers and the start, command accept and interrupt enable outputs.
  frozen_state_a: assert property (
    !CE |=> $stable(xfer_ctrl) && $stable(drive_sel) &&
    $stable(int_reason) && $stable(err_report) && $stable(XFER_START) &&
    $stable(CMD_ACCEPT) && $stable(HOST_INT_OE))
    else $error("state changed while clock enable was low");
endmodule
`default_nettype wire

// ==== atcr_host_model.sv ====
// Behavioural host controller that drives the task-file side of the block.
`default_nettype none
module atcr_host_model (
  input wire logic clk,
  output logic sel_wr,
  output logic [7:0] sel_data,
  output logic int_dis,
  output logic cmd_wr,
  input wire logic int_o,
  input wire logic int_oe,
  output logic int_line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sel_wr = 1'b0;
    sel_data = 8'h00;
    int_dis = 1'b0;
    cmd_wr = 1'b0;
  end

  // A released pin falls to the pull-down level.
  assign int_line = int_oe ? int_o : 1'b0;

  task automatic sel_write(input logic drv);
    @(posedge clk);
    sel_wr <= 1'b1;
    sel_data <= {3'h7, drv, 4'h0};
    @(posedge clk);
    sel_wr <= 1'b0;
    // The data bus shows no stale value once the strobe is gone.
    sel_data <= ~sel_data;
  endtask

  task automatic cmd_write();
    @(posedge clk);
    cmd_wr <= 1'b1;
    @(posedge clk);
    cmd_wr <= 1'b0;
  endtask

  task automatic set_disable(input logic v);
    @(posedge clk);
    int_dis <= v;
  endtask
endmodule
`default_nettype wire

// ==== atapi_transfer_control_regs_tb.sv ====
// Self-checking testbench of the transfer control register block.
`include "atcr_cfg.svh"
`default_nettype none
module atapi_transfer_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b0;
  logic ce = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata;
  logic int_req = 1'b0;
  logic trig = 1'b0;
  logic sel_wr, sel_cmd, int_dis, int_o, int_oe, int_line;
  logic [7:0] sel_data, err_rep;
  logic cmd_acc, selected, own, start, dma, multi, ultra, fixed12, use_cnt;
  logic [2:0] reason, route;
  logic [31:0] xmax;
  int n_fail = 0;
  int n_compared = 0;

  always #2.5 clk = ~clk;

  atcr_host_model i_atcr_host_model (.clk(clk), .sel_wr(sel_wr),
    .sel_data(sel_data), .int_dis(int_dis), .cmd_wr(sel_cmd),
    .int_o(int_o), .int_oe(int_oe), .int_line(int_line));

  atcr_regs i_atcr_regs (.CLK(clk), .RST(rst), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata),
    .HOST_SEL_WR(sel_wr), .HOST_SEL_DATA(sel_data),
    .HOST_INT_DISABLE(int_dis), .HOST_INT_REQ(int_req),
    .HOST_CMD_WR(sel_cmd), .CMD_ACCEPT(cmd_acc), .SELECTED(selected),
    .OWN_DEVICE(own), .HOST_INT_O(int_o), .HOST_INT_OE(int_oe),
    .INT_REASON(reason), .ERROR_REPORT(err_rep), .XFER_TRIGGER(trig),
    .XFER_START(start), .XFER_ROUTE(route), .XFER_DMA(dma),
    .XFER_MULTIWORD(multi), .XFER_ULTRA(ultra), .XFER_FIXED12(fixed12),
    .XFER_USE_COUNTER(use_cnt), .XFER_MAX(xmax));

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  // Route, dma, multi, ultra, fixed and limit, worked out from the control byte.
  function automatic logic [39:0] exp_attr(input logic [7:0] c);
    logic [2:0] r;
    logic fx;
    logic [31:0] m;
    r = c[2:0];
    fx = (r == 3'h4) || (r == 3'h5);
    m = fx ? 32'h0000000c : ((r < 3'h2 && !c[5]) ? 32'h0000ffff : 32'hffffffff);
    return {1'b0, r, c[5] & (r != 3'h4), c[6],
      c[4] & c[5] & c[6] & (r != 3'h4), fx, m};
  endfunction

  task automatic t_reset();
    rd_chk(`ATCR_OFF_XFER_CTRL, 8'h08);
    rd_chk(`ATCR_OFF_DRIVE_SEL, 8'he0);
    rd_chk(`ATCR_OFF_INT_REASON, 8'h00);
    rd_chk(`ATCR_OFF_ERR_REPORT, 8'h00);
    chk({own, selected, start, route, xmax}, {2'b10, 36'h0});
  endtask

  task automatic t_regs();
    wr(`ATCR_OFF_INT_REASON, 8'hff);
    wr(`ATCR_OFF_ERR_REPORT, 8'hff);
    wr(`ATCR_OFF_XFER_CTRL, 8'hff);
    chk({reason, err_rep}, {3'h7, 8'hfe});
    rd_chk(`ATCR_OFF_XFER_CTRL, 8'h7f);
    rd_chk(`ATCR_OFF_INT_REASON, 8'h07);
    rd_chk(`ATCR_OFF_ERR_REPORT, 8'hfe);
    rd_chk(16'hff8f, 8'h00);
    wr(`ATCR_OFF_ERR_REPORT, 8'h5a);
    rd_chk(`ATCR_OFF_ERR_REPORT, 8'h5a);
    // A frozen block must ignore a write strobe.
    ce <= 1'b0;
    wr(`ATCR_OFF_ERR_REPORT, 8'h00);
    ce <= 1'b1;
    rd_chk(`ATCR_OFF_ERR_REPORT, 8'h5a);
  endtask

  task automatic t_select();
    wr(`ATCR_OFF_XFER_CTRL, 8'h00);
    chk(own, 1'b0);
    i_atcr_host_model.sel_write(1'b0);
    #1;
    chk(selected, 1'b1);
    i_atcr_host_model.cmd_write();
    #1;
    chk(cmd_acc, 1'b1);
    int_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({int_oe, int_o, int_line}, 3'h7);
    i_atcr_host_model.set_disable(1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk({int_oe, int_line}, 2'b00);
    i_atcr_host_model.set_disable(1'b0);
    i_atcr_host_model.sel_write(1'b1);
    #1;
    chk(selected, 1'b0);
    i_atcr_host_model.cmd_write();
    #1;
    chk({cmd_acc, int_oe}, 2'b00);
    wr(`ATCR_OFF_XFER_CTRL, 8'h08);
    chk({own, selected}, 2'b11);
    wr(`ATCR_OFF_DRIVE_SEL, 8'h0f);
    rd_chk(`ATCR_OFF_DRIVE_SEL, 8'he0);
    chk(selected, 1'b0);
    wr(`ATCR_OFF_DRIVE_SEL, 8'hff);
    rd_chk(`ATCR_OFF_DRIVE_SEL, 8'hf0);
    chk(selected, 1'b1);
    int_req <= 1'b0;
  endtask

  task automatic t_routes();
    logic [7:0] tbl [8];
    logic [39:0] last;
    logic ok;
    tbl = '{8'h00, 8'h21, 8'h72, 8'h53, 8'h74, 8'h65, 8'h66, 8'h07};
    last = '0;
    foreach (tbl[i]) begin
      wr(`ATCR_OFF_XFER_CTRL, tbl[i]);
      ok = (tbl[i][2:1] != 2'b11);
      @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      #1;
      chk(start, ok);
      if (ok) begin
        last = exp_attr(tbl[i]);
      end
      chk({1'b0, route, dma, multi, ultra, fixed12, xmax}, last);
      if (ok && tbl[i][2:1] != 2'b01) begin
        chk(use_cnt, tbl[i][2:0] < 3'h2);
      end
      @(posedge clk);
      #1;
      chk(start, 1'b0);
    end
  endtask

  task automatic t_mid_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
  endtask

  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    // Reset rises by a nonblocking assignment at time zero so the asynchronous reset sees a real edge.
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_select();
    t_routes();
    t_mid_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
